// ===== rtl/flag_cell_row.sv
// Purpose: one 16-bit flag register with hardware set and software write
// Assumes: set pulses are synchronous to ref_clk
// Notes: a hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
module flag_cell_row #(
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [15:0] set_req,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] flags
);

  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;

  // Write replaces, source requests OR on top so none is lost
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_en) begin
      nxt_flags = wr_data;
    end
    nxt_flags = (nxt_flags | set_req) & IMPL;
  end

  // Flags never clear by themselves
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_ff <= irq_bank_pkg::RESET_VALUE;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule : flag_cell_row

// ===== rtl/irq_flag_bank.sv
// Purpose: interrupt flag and enable register bank behind an APB slave
// Assumes: source requests are synchronous one-cycle or level pulses
// Notes: serviced request vector is registered; small variant via parameter
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] src_req_0,
  input wire logic [15:0] src_req_1,
  input wire logic [15:0] src_req_2,
  input wire logic [15:0] src_req_3,
  input wire logic [15:0] src_req_4,
  input wire logic [15:0] src_req_5,
  output logic [15:0] pending_0,
  output logic [15:0] pending_1,
  output logic [15:0] pending_2,
  output logic [15:0] pending_3,
  output logic [15:0] pending_4,
  output logic [15:0] pending_5,
  output logic any_pending,
  output logic irq
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Implemented bits of one register for the chosen variant
  function automatic logic [15:0] impl_mask(input int idx);
    if (SMALL_VARIANT) begin
      impl_mask = irq_bank_pkg::SMALL_MASK[idx];
    end else begin
      impl_mask = irq_bank_pkg::FULL_MASK[idx];
    end
  endfunction : impl_mask

  // Hit on one word of an 8-word window
  function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] base, input int idx);
    word_hit = (addr == (base + 8'(idx * 4)));
  endfunction : word_hit

  irq_bank_pkg::apb_req_t req;
  logic access;
  logic wr_access;
  logic rd_access;

  // First access cycle is taken; a write lands only at the pready edge the master sees
  assign req = '{addr: paddr, wdata: pwdata, write: pwrite};
  assign access = psel && penable && !pready;
  assign wr_access = psel && penable && pready && req.write;
  assign rd_access = access && !req.write;

  // ****************************************
  // Flag and enable registers
  // ****************************************
  logic [15:0] src_vec [irq_bank_pkg::NUM_REGS];
  irq_bank_pkg::flag_word_t flag_vec [irq_bank_pkg::NUM_REGS];
  logic [15:0] enable_ff [irq_bank_pkg::NUM_REGS];
  logic [15:0] serviced [irq_bank_pkg::NUM_REGS];
  logic [irq_bank_pkg::NUM_REGS-1:0] flag_wr;
  logic [irq_bank_pkg::NUM_REGS-1:0] enable_wr;

  assign src_vec[0] = src_req_0;
  assign src_vec[1] = src_req_1;
  assign src_vec[2] = src_req_2;
  assign src_vec[3] = src_req_3;
  assign src_vec[4] = src_req_4;
  assign src_vec[5] = src_req_5;

  genvar gi;
  generate
    for (gi = 0; gi < irq_bank_pkg::NUM_REGS; gi++) begin : g_reg
      assign flag_wr[gi] = wr_access && word_hit(req.addr, irq_bank_pkg::FLAG_BASE, gi);
      assign enable_wr[gi] = wr_access && word_hit(req.addr, irq_bank_pkg::ENABLE_BASE, gi);

      // Flag row, masked per variant so absent sources never set
      flag_cell_row #(
        .IMPL(impl_mask(gi))
      ) u_row (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_req(src_vec[gi]),
        .wr_en(flag_wr[gi]),
        .wr_data(req.wdata[15:0]),
        .flags(flag_vec[gi].bits)
      );

      // Enable bits share the flag layout, clear at reset
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          enable_ff[gi] <= irq_bank_pkg::RESET_VALUE;
        end else if (enable_wr[gi]) begin
          enable_ff[gi] <= req.wdata[15:0] & impl_mask(gi);
        end
      end

      // Enable gates forwarding only; flag left as is
      assign serviced[gi] = flag_vec[gi].bits & enable_ff[gi];
    end
  endgenerate

  // Registered forwarding so outputs come from flip-flops
  logic [15:0] pending_ff [irq_bank_pkg::NUM_REGS];
  logic any_pending_ff;
  logic [irq_bank_pkg::NUM_REGS-1:0] row_any;

  generate
    for (gi = 0; gi < irq_bank_pkg::NUM_REGS; gi++) begin : g_any
      assign row_any[gi] = |serviced[gi];
    end
  endgenerate

  // Pending vector to the CPU arbitration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pending_ff <= '{default: 16'h0000};
      any_pending_ff <= 1'b0;
    end else begin
      pending_ff <= serviced;
      any_pending_ff <= |row_any;
    end
  end

  assign pending_0 = pending_ff[0];
  assign pending_1 = pending_ff[1];
  assign pending_2 = pending_ff[2];
  assign pending_3 = pending_ff[3];
  assign pending_4 = pending_ff[4];
  assign pending_5 = pending_ff[5];
  assign any_pending = any_pending_ff;

  // ****************************************
  // Bank event status and interrupt
  // ****************************************
  logic [irq_bank_pkg::EV_BITS-1:0] ev_status_ff;
  logic [irq_bank_pkg::EV_BITS-1:0] ev_mask_ff;
  logic [irq_bank_pkg::EV_BITS-1:0] ev_set;
  logic [irq_bank_pkg::EV_BITS-1:0] ev_clr;
  logic irq_ff;
  logic any_src;
  logic any_force;
  logic any_clear;
  logic [irq_bank_pkg::NUM_REGS-1:0] src_hit;
  logic [irq_bank_pkg::NUM_REGS-1:0] wr_ones;

  generate
    for (gi = 0; gi < irq_bank_pkg::NUM_REGS; gi++) begin : g_ev
      assign src_hit[gi] = |(src_vec[gi] & impl_mask(gi));
      assign wr_ones[gi] = flag_wr[gi] && |(req.wdata[15:0] & impl_mask(gi) & ~flag_vec[gi].bits);
    end
  endgenerate

  // Events: new request, software force, any software write to a flag register
  assign any_src = |src_hit;
  assign any_force = |wr_ones;
  assign any_clear = |flag_wr;
  assign ev_set = {any_clear, any_force, any_src};
  assign ev_clr = (wr_access && req.addr == irq_bank_pkg::IRQ_STATUS_OFFS) ?
    req.wdata[irq_bank_pkg::EV_BITS-1:0] : '0;

  // Sticky, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_status_ff <= '0;
    end else begin
      ev_status_ff <= (ev_status_ff & ~ev_clr) | ev_set;
    end
  end

  // Mask register for the event interrupt
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_mask_ff <= '0;
    end else if (wr_access && req.addr == irq_bank_pkg::IRQ_MASK_OFFS) begin
      ev_mask_ff <= req.wdata[irq_bank_pkg::EV_BITS-1:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(ev_status_ff & ev_mask_ff);
    end
  end

  assign irq = irq_ff;

  // ****************************************
  // APB read and response
  // ****************************************
  logic [31:0] rd_word;
  logic addr_ok;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Read mux; unimplemented bits already zero in storage
  always_comb begin
    rd_word = irq_bank_pkg::SLVERR_DATA;
    addr_ok = 1'b0;
    for (int i = 0; i < irq_bank_pkg::NUM_REGS; i++) begin
      if (word_hit(req.addr, irq_bank_pkg::FLAG_BASE, i)) begin
        rd_word = {16'h0000, flag_vec[i].bits};
        addr_ok = 1'b1;
      end
      if (word_hit(req.addr, irq_bank_pkg::ENABLE_BASE, i)) begin
        rd_word = {16'h0000, enable_ff[i]};
        addr_ok = 1'b1;
      end
    end
    if (req.addr == irq_bank_pkg::IRQ_STATUS_OFFS) begin
      rd_word = {29'h00000000, ev_status_ff};
      addr_ok = 1'b1;
    end
    if (req.addr == irq_bank_pkg::IRQ_MASK_OFFS) begin
      rd_word = {29'h00000000, ev_mask_ff};
      addr_ok = 1'b1;
    end
    if (req.addr == irq_bank_pkg::CONFIG_OFFS) begin
      rd_word = {31'h00000000, SMALL_VARIANT};
      addr_ok = !req.write;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !addr_ok;
      prdata_ff <= rd_access ? rd_word : 32'h00000000;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

endmodule : irq_flag_bank

// ===== shared/irq_bank_pkg.sv
// Purpose: constants, masks and carriers for the interrupt flag/enable bank
// Assumes: APB slave, 32-bit data, 16-bit registers in the low half of each word
// Notes: offsets are per-word byte addresses
//
// Behaviour
// - Source request sets its flag bit
// - Unassigned bits ignore writes, read zero
// - Flag register zero source layout
// - Flag register one source layout
// - Flag register two: timer3 gate bit 5
// - Flag register three: syncport2 collision/event
// - Flag register four: voltage, serial errors
// - Flag register five: low power wake
// - Small variants drop second-instance bits
// - Enable register one mirrors flag one
// - Enable gates request, flag untouched
package irq_bank_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NUM_REGS = 6;
  localparam logic [7:0] FLAG_BASE = 8'h00;
  localparam logic [7:0] ENABLE_BASE = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFFS = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h44;
  localparam logic [7:0] CONFIG_OFFS = 8'h48;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [31:0] SLVERR_DATA = 32'h00000000;

  // ****************************************
  // Implemented bits, full and small variants
  // ****************************************
  localparam logic [15:0] FULL_MASK [NUM_REGS] = '{
    16'hB9CD, 16'hEA1F, 16'h0020, 16'h0006, 16'h0106, 16'h0001};
  localparam logic [15:0] SMALL_MASK [NUM_REGS] = '{
    16'hB9CD, 16'h201F, 16'h0020, 16'h0000, 16'h0102, 16'h0001};

  // Event bits of the bank's own status register
  localparam int EV_REQUEST = 0;
  localparam int EV_FORCE = 1;
  localparam int EV_CLEAR = 2;
  localparam int EV_BITS = 3;

  typedef struct packed {
    logic [15:0] bits;
  } flag_word_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic write;
  } apb_req_t;

endpackage : irq_bank_pkg

// ===== tb/irq_bank_asserts.sv
// Purpose: port checks for the flag/enable bank
// Assumes: one clock, synchronous reset
// Notes: pending lags flag writes by two edges
`timescale 1ns/1ps
module irq_bank_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] pending_0,
  input wire logic [15:0] pending_2
);
  // ****************************************
  // Bus and pending relations
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // One wait state, answer is a single pulse
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper half set");
  a_pend0_impl: assert property ((pending_0 & ~16'hB9CD) == 16'h0) else $error("pending0 bad bit");
  a_pend2_impl: assert property ((pending_2 & ~16'h0020) == 16'h0) else $error("pending2 bad bit");
  // Only a software write may drop a pending flag
  a_pend_sticky: assert property (pending_0[0] && !$past(psel && penable && pwrite) |=> pending_0[0])
    else $error("flag dropped");
endmodule : irq_bank_asserts

bind irq_flag_bank irq_bank_asserts chk (.ref_clk, .reset, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .pending_0, .pending_2);

// ===== tb/tb.sv
// Purpose: self-checking bench for the flag/enable bank
// Assumes: full variant plus a small-variant copy, APB with one wait state
// Notes: flags and enables share one mask per word
`timescale 1ns/1ps
module tb;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, any_pending, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] prdata2, rd2;
  logic [15:0] src [6];
  logic [15:0] pend [6];
  int error_cnt = 0;
  int comparisons = 0;
  localparam logic [15:0] IMPL [6] = '{16'hB9CD, 16'hEA1F, 16'h0020, 16'h0006, 16'h0106, 16'h0001};
  // Small variant drops serial2, syncport2, timer4 and compare3 bits
  localparam logic [15:0] IMPL_SMALL [6] = '{16'hB9CD, 16'h201F, 16'h0020, 16'h0000, 16'h0102, 16'h0001};

  irq_flag_bank #(.SMALL_VARIANT(1'b0)) dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_req_0(src[0]), .src_req_1(src[1]), .src_req_2(src[2]),
    .src_req_3(src[3]), .src_req_4(src[4]), .src_req_5(src[5]), .pending_0(pend[0]), .pending_1(pend[1]),
    .pending_2(pend[2]), .pending_3(pend[3]), .pending_4(pend[4]), .pending_5(pend[5]), .any_pending, .irq);

  // Small variant on the same bus; only its read data is judged
  irq_flag_bank #(.SMALL_VARIANT(1'b1)) dut_small (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(prdata2), .pready(), .pslverr(), .src_req_0(src[0]), .src_req_1(src[1]), .src_req_2(src[2]),
    .src_req_3(src[3]), .src_req_4(src[4]), .src_req_5(src[5]), .pending_0(), .pending_1(), .pending_2(),
    .pending_3(), .pending_4(), .pending_5(), .any_pending(), .irq());

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict;
    $display("Comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // One transfer; the leading edge keeps releases and setups apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      print_verdict();
    end
    rd = prdata;
    rd2 = prdata2;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_masks;
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(4 * i), 32'h0);
      check("flag reset", 32'h0, rd);
      apb(0, 8'(8'h20 + 4 * i), 32'h0);
      check("enable reset", 32'h0, rd);
      apb(1, 8'(4 * i), 32'hFFFFFFFF);
      apb(0, 8'(4 * i), 32'h0);
      check("flag force", {16'h0, IMPL[i]}, rd);
      check("small flag force", {16'h0, IMPL_SMALL[i]}, rd2);
      apb(1, 8'(8'h20 + 4 * i), 32'hFFFFFFFF);
      apb(0, 8'(8'h20 + 4 * i), 32'h0);
      check("enable mask", {16'h0, IMPL[i]}, rd);
      check("small enable mask", {16'h0, IMPL_SMALL[i]}, rd2);
      apb(1, 8'(4 * i), 32'h0);
      apb(1, 8'(8'h20 + 4 * i), 32'h0);
      apb(0, 8'(4 * i), 32'h0);
      check("flag clear", 32'h0, rd);
    end
  endtask : t_masks

  task automatic t_source;
    for (int i = 0; i < 6; i++) begin
      src[i] <= 16'hFFFF;
      @(posedge ref_clk);
      src[i] <= 16'h0;
      apb(0, 8'(4 * i), 32'h0);
      check("flag set", {16'h0, IMPL[i]}, rd);
      check("pending gated", 32'h0, {16'h0, pend[i]});
      apb(1, 8'(8'h20 + 4 * i), {16'h0, IMPL[i]});
      apb(0, 8'(4 * i), 32'h0);
      check("flag kept", {16'h0, IMPL[i]}, rd);
      check("pending", {16'h0, IMPL[i]}, {16'h0, pend[i]});
      check("any", 32'h1, {31'h0, any_pending});
      apb(1, 8'(4 * i), 32'h0);
      apb(1, 8'(8'h20 + 4 * i), 32'h0);
    end
  endtask : t_source

  task automatic t_refused;
    apb(1, 8'h18, 32'hFFFF);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(0, 8'h18, 32'h0);
    check("unmapped data", 32'h0, rd);
    check("unmapped read err", 32'h1, {31'h0, err});
    apb(1, 8'h48, 32'h1);
    check("config err", 32'h1, {31'h0, err});
    apb(0, 8'h48, 32'h0);
    check("config full", 32'h0, rd);
    check("config small", 32'h1, rd2);
  endtask : t_refused

  // Raise, mask and clear the event interrupt
  task automatic t_irq;
    apb(1, 8'h44, 32'h0);
    apb(1, 8'h40, 32'h7);
    src[3] <= 16'h0002;
    @(posedge ref_clk);
    src[3] <= 16'h0;
    apb(0, 8'h40, 32'h0);
    check("status", 32'h1, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1, 8'h44, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("irq raised", 32'h1, {31'h0, irq});
    apb(1, 8'h40, 32'h1);
    repeat (3) @(posedge ref_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    // Forcing a flag by software raises the force and write events
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h40, 32'h0);
    check("force events", 32'h6, rd);
    apb(1, 8'h00, 32'h0);
  endtask : t_irq

  // Free-running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = '{default: 16'h0};
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_masks();
    t_source();
    t_refused();
    t_irq();
    print_verdict();
  end
endmodule : tb
